// [design/hsx_dev.sv]
// Behaviour
// R1 - Strobe or preload event sets its latch
// R2 - Latch clears only by its reset bit
// R3 - Controller pulses reset bit for one scan
// R4 - Four bits show commanded output states
// R5 - Ready set after self tests pass
// R6 - Error sets flag and status code word
// R7 - Clear-error command clears flag and code
// R8 - Dual: live disable level per counter
// R9 - Single: live disable and home switch levels
// R10 - Single: home found bit when home reached
// R11 - Controller sends command word every scan
// R12 - Command bits 9-12 gate four outputs
// R13 - Dual word layout, counters at 4-9, 10-15
// R14 - Single word layout, unused words read zero
// R15 - Two-word values coherent, low word first
`timescale 1ns/100ps
module hsx_dev (
	// Clock and reset.
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Link to the controller.
	hsx_if.dev                        link,
	// Configuration: 1 selects the single-counter layout.
	input  wire logic                 cfg_single,
	// Counting logic events, one-cycle pulses.
	input  wire logic [5:0]           latch_evt,
	input  wire logic                 home_found_evt,
	input  wire logic                 err_evt,
	input  wire hsx_pkg::hsx_word_t   err_code,
	// Self test result.
	input  wire logic                 selftest_done,
	input  wire logic                 selftest_fail,
	// Pins: disable inputs and home limit switch.
	input  wire logic [1:0]           disable_pin,
	input  wire logic                 home_pin,
	// Counter values.
	input  wire hsx_pkg::hsx_word_t   rate1,
	input  wire hsx_pkg::hsx_word_t   rate2,
	input  wire logic [31:0]          accum1,
	input  wire logic [31:0]          accum2,
	input  wire logic [31:0]          capture [0:3],
	// Requested output states from the preset logic.
	input  wire logic [3:0]           out_req,
	// Gated outputs and home command to the counting logic.
	output logic [3:0]                out_on,
	output logic                      home_cmd
);
	import hsx_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [5:0]      latch_q;                         // Sticky strobe and preload latches.
	logic            home_found_q;                    // Sticky home found flag.
	logic            ready_q;                         // Ready flag.
	logic            err_q;                           // Error flag.
	hsx_word_t       code_q;                          // Status code word.
	hsx_word_t       cmd_q;                           // Command word of the last scan.
	logic [2:0]      pin_s1_q;                        // First synchroniser stage for pins.
	logic [2:0]      pin_s2_q;                        // Second synchroniser stage for pins.
	logic [3:0]      out_q;                           // Commanded output states.
	hsx_word_t       snap_q [1:15];                   // Scan snapshot of the word image.
	hsx_word_t       img    [1:15];                   // Live word image.
	hsx_word_t       data_q;                          // Read data register.
	logic            ack_q;                           // Read answer.
	logic [5:0]      latch_use;                       // Latch bits used in this layout.
	logic [5:0]      rst_bits;                        // Reset bits taken this cycle.
	logic            clr_err;                         // Clear error taken this cycle.

	// Reset and clear bits only act in the cycle a scan delivers them.
	assign rst_bits  = link.scan_strobe ? link.cmd_word[CB_RESET +: LATCH_N] : 6'h00;
	assign clr_err   = link.scan_strobe & link.cmd_word[CB_CLR_ERR];
	assign latch_use = cfg_single ? SINGLE_LATCH_MASK : 6'h3F;

	////////////////////////////////////////////////////////////////////////////
	// Command word storage: the last scan's word stays in force.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= CMD_RST;
		end else if (link.scan_strobe) begin
			cmd_q <= link.cmd_word;                   // R11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strobe and preload latches; a new event wins over a reset bit.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= 6'h00;
		end else begin
			latch_q <= ((latch_q & ~rst_bits) | latch_evt) & latch_use; // R1 R2
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Home found latch: set when homing reaches home, dropped with the home command.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			home_found_q <= 1'b0;
		end else if (cfg_single && home_found_evt) begin
			home_found_q <= 1'b1;                     // R10
		end else if (!cmd_q[CB_HOME_CMD] || !cfg_single) begin
			home_found_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Ready is raised once the self tests end without failure and kept until reset.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_q <= 1'b0;
		end else if (selftest_done && !selftest_fail) begin
			ready_q <= 1'b1;                          // R5
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Error flag and code; a new error in the clearing cycle survives.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q  <= 1'b0;
			code_q <= WORD_RST;
		end else if (err_evt) begin
			err_q  <= 1'b1;                           // R6
			code_q <= err_code;                       // R6
		end else if (clr_err) begin
			err_q  <= 1'b0;                           // R7
			code_q <= WORD_RST;                       // R7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the disable and home switch inputs.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {home_pin, disable_pin};
			pin_s2_q <= pin_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs: a request only turns an output on while its enable bit is set.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= 4'h0;
		end else begin
			out_q <= out_req & cmd_q[CB_OUT_EN +: OUT_N]; // R12
		end
	end

	assign out_on   = out_q;
	assign home_cmd = cmd_q[CB_HOME_CMD] & cfg_single;

	////////////////////////////////////////////////////////////////////////////
	// Status word, rebuilt every cycle from the flags above.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.status_bits <= STATUS_RST;
		end else begin
			link.status_bits                       <= STATUS_RST;
			link.status_bits[SB_LATCH +: LATCH_N]  <= latch_q;     // R1
			// Dual: both disables; single: disable 1 and home switch.
			link.status_bits[SB_LIVE]              <= pin_s2_q[0]; // R8 R9
			link.status_bits[SB_LIVE + 1]          <= cfg_single ? pin_s2_q[2] : pin_s2_q[1]; // R8 R9
			link.status_bits[SB_HOME_FOUND]        <= home_found_q; // R10
			link.status_bits[SB_OUT +: OUT_N]      <= out_q;       // R4
			link.status_bits[SB_READY]             <= ready_q;     // R5
			link.status_bits[SB_ERROR]             <= err_q;       // R6
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Live word image in the layout of the selected configuration.
	always_comb begin
		for (int i = 1; i <= IMG_WORDS; i++) begin
			img[i] = WORD_RST;
		end
		img[W_STATUS_CODE] = code_q;                  // R6
		img[W_RATE1]       = rate1;
		img[W_ACC1]        = accum1[15:0];            // R15
		img[W_ACC1 + 4'h1] = accum1[31:16];           // R15
		img[W_CAP_A1]      = capture[0][15:0];
		img[W_CAP_A1+4'h1] = capture[0][31:16];
		img[W_CAP_B1]      = capture[1][15:0];
		img[W_CAP_B1+4'h1] = capture[1][31:16];
		if (cfg_single) begin
			img[W_ACC2]        = capture[2][15:0];    // R14
			img[W_ACC2 + 4'h1] = capture[2][31:16];   // R14
		end else begin
			img[W_RATE2]         = rate2;             // R13
			img[W_ACC2]          = accum2[15:0];      // R13
			img[W_ACC2 + 4'h1]   = accum2[31:16];     // R13
			img[W_CAP_A2]        = capture[2][15:0];  // R13
			img[W_CAP_A2 + 4'h1] = capture[2][31:16]; // R13
			img[W_CAP_B2]        = capture[3][15:0];  // R13
			img[W_CAP_B2 + 4'h1] = capture[3][31:16]; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Snapshot at the scan strobe so both halves of a value come from one instant.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 1; i <= IMG_WORDS; i++) begin
				snap_q[i] <= WORD_RST;
			end
		end else if (link.scan_strobe) begin
			for (int i = 1; i <= IMG_WORDS; i++) begin
				snap_q[i] <= img[i];                  // R15
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word reads: answered one cycle later; word number 0 reads zero.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q  <= 1'b0;
			data_q <= WORD_RST;
		end else begin
			ack_q <= link.word_rd;
			if (link.word_rd) begin
				data_q <= (link.word_sel == 4'h0) ? WORD_RST : snap_q[link.word_sel]; // R13 R14
			end
		end
	end

	assign link.word_ack  = ack_q;
	assign link.word_data = data_q;
endmodule : hsx_dev

// [design/hsx_pkg.sv]
package hsx_pkg;
	// Geometry of the scan exchange.
	localparam int WORD_W      = 16;                  // Width of every image word and of the command word.
	localparam int IMG_WORDS   = 15;                  // Input words sent per scan, numbered 1 to 15.
	localparam int SEL_W       = 4;                   // Width of a word number.
	localparam int LATCH_N     = 6;                   // Strobe and preload latch bits.
	localparam int OUT_N       = 4;                   // Outputs of the module.
	localparam int DIS_N       = 2;                   // Live input bits reported beside the latches.

	// Word numbers of the input word image.
	localparam logic [3:0] W_STATUS_CODE = 4'h1;      // Status code word.
	localparam logic [3:0] W_RATE1       = 4'h2;      // Counts per timebase, counter 1.
	localparam logic [3:0] W_RATE2       = 4'h3;      // Counts per timebase, counter 2 (zero when single).
	localparam logic [3:0] W_ACC1        = 4'h4;      // Accumulator of counter 1, low half.
	localparam logic [3:0] W_CAP_A1      = 4'h6;      // First capture register, low half.
	localparam logic [3:0] W_CAP_B1      = 4'h8;      // Second capture register, low half.
	localparam logic [3:0] W_ACC2        = 4'hA;      // Dual: accumulator 2; single: third capture.
	localparam logic [3:0] W_CAP_A2      = 4'hC;      // Dual: counter 2 first capture; single: zero.
	localparam logic [3:0] W_CAP_B2      = 4'hE;      // Dual: counter 2 second capture; single: zero.

	// Status bit positions.
	localparam int SB_LATCH      = 0;                 // Latch bits 0 to 5.
	localparam int SB_LIVE       = 6;                 // Live input bits 6 and 7.
	localparam int SB_HOME_FOUND = 8;                 // Home found, single configuration only.
	localparam int SB_OUT        = 9;                 // Output status bits 9 to 12.
	localparam int SB_READY      = 14;                // Module ready.
	localparam int SB_ERROR      = 15;                // Error present.

	// Command bit positions.
	localparam int CB_RESET      = 0;                 // Latch reset bits 0 to 5.
	localparam int CB_HOME_CMD   = 8;                 // Home command, single configuration only.
	localparam int CB_OUT_EN     = 9;                 // Output enable bits 9 to 12.
	localparam int CB_CLR_ERR    = 15;                // Clear error.

	// Reset values.
	localparam logic [15:0] STATUS_RST = 16'h0000;    // Status word after reset.
	localparam logic [15:0] CMD_RST    = 16'h0000;    // Command word after reset: all outputs disabled.
	localparam logic [15:0] WORD_RST   = 16'h0000;    // Image words after reset.

	// Single configuration has three captures, so its live latch bit 5 stays clear.
	localparam logic [5:0] SINGLE_LATCH_MASK = 6'h1F; // Latch bits in use when single.

	typedef logic [15:0] hsx_word_t;                  // One image or command word.

	// Host sequencer states.
	typedef enum logic [3:0] {
		HSX_IDLE   = 4'h1,
		HSX_STROBE = 4'h2,
		HSX_READ   = 4'h4,
		HSX_WAIT   = 4'h8
	} hsx_state_t;
endpackage : hsx_pkg

// [design/hsx_if.sv]
`timescale 1ns/100ps
interface hsx_if;
	import hsx_pkg::*;
	// Scan start with the command word, from the controller.
	logic                  scan_strobe;               // One-cycle pulse, command word valid with it.
	hsx_word_t             cmd_word;                  // Command word.
	// Word reads of the input image.
	logic                  word_rd;                   // One-cycle read request.
	logic [SEL_W-1:0]      word_sel;                  // Word number 1 to 15, valid with word_rd.
	hsx_word_t             word_data;                 // Read data, valid with word_ack.
	logic                  word_ack;                  // One-cycle answer to word_rd.
	// Live status bits from the module.
	hsx_word_t             status_bits;               // Status word.

	modport dev  (input scan_strobe, cmd_word, word_rd, word_sel,
		output word_data, word_ack, status_bits);
	modport host (output scan_strobe, cmd_word, word_rd, word_sel,
		input word_data, word_ack, status_bits);
endinterface : hsx_if

// [design/hsx_host.sv]
`timescale 1ns/100ps
module hsx_host (
	// Clock and reset.
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Link to the module.
	hsx_if.host                       link,
	// User control of the scan.
	input  wire logic                 scan_go,
	input  wire logic [3:0]           out_enable,
	input  wire logic                 home_request,
	input  wire logic                 err_ack,
	output logic                      scan_busy,
	output logic                      scan_done,
	// Results of the last scan.
	output hsx_pkg::hsx_word_t        status_q,
	input  wire logic [3:0]           user_sel,
	output hsx_pkg::hsx_word_t        user_data
);
	import hsx_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	hsx_state_t        state_q;                       // Scan sequencer state.
	logic [SEL_W-1:0]  sel_q;                         // Word being read.
	hsx_word_t         image_q [1:15];                // Words of the last scan.
	logic [5:0]        rst_q;                         // Reset bits for the next scan.
	logic              clr_q;                         // Clear error for the next scan.
	logic              done_q;                        // Scan finished pulse.
	hsx_word_t         cmd_q;                         // Command word being sent.
	hsx_word_t         user_q;                        // User read data.

	////////////////////////////////////////////////////////////////////////////
	// Scan sequencer: strobe the command word, then read words 1 to 15.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= HSX_IDLE;
			sel_q   <= 4'h1;
		end else begin
			case (state_q)
				HSX_IDLE: begin
					if (scan_go) begin
						state_q <= HSX_STROBE;
					end
				end
				HSX_STROBE: begin
					sel_q   <= 4'h1;
					state_q <= HSX_READ;
				end
				HSX_READ: begin
					state_q <= HSX_WAIT;
				end
				HSX_WAIT: begin
					if (link.word_ack) begin
						if (sel_q == 4'hF) begin
							state_q <= HSX_IDLE;
						end else begin
							sel_q   <= sel_q + 4'h1;
							state_q <= HSX_READ;
						end
					end
				end
				default: begin
					state_q <= HSX_IDLE;
				end
			endcase
		end
	end

	// One command word goes out with every scan strobe.
	assign link.scan_strobe = (state_q == HSX_STROBE); // R11
	assign link.word_rd     = (state_q == HSX_READ);
	assign link.word_sel    = sel_q;
	assign link.cmd_word    = cmd_q;
	assign scan_busy        = (state_q != HSX_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Command word built when a scan starts, held through the scan.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= CMD_RST;
		end else if (state_q == HSX_IDLE && scan_go) begin
			cmd_q                         <= CMD_RST;
			cmd_q[CB_RESET +: LATCH_N]    <= rst_q;        // R2 R3
			cmd_q[CB_HOME_CMD]            <= home_request;
			cmd_q[CB_OUT_EN +: OUT_N]     <= out_enable;
			cmd_q[CB_CLR_ERR]             <= clr_q;        // R7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset bits: a latch read as 1, and not reset by the scan just read, is reset on the next scan, then returned to 0.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 6'h00;
		end else if (state_q == HSX_IDLE && scan_go) begin
			rst_q <= 6'h00;                            // R3
		end else if (done_q) begin
			rst_q <= status_q[SB_LATCH +: LATCH_N] & ~cmd_q[CB_RESET +: LATCH_N]; // R3
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clear error: an acknowledged error is cleared on the next scan only.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_q <= 1'b0;
		end else if (err_ack) begin
			clr_q <= 1'b1;                             // R7
		end else if (state_q == HSX_IDLE && scan_go) begin
			clr_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Collect each word as its answer arrives, and the status word with the answer to word 15.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 1; i <= IMG_WORDS; i++) begin
				image_q[i] <= WORD_RST;
			end
			status_q <= STATUS_RST;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (state_q == HSX_WAIT && link.word_ack) begin
				image_q[sel_q] <= link.word_data;
				if (sel_q == 4'hF) begin
					status_q <= link.status_bits;
					done_q   <= 1'b1;
				end
			end
		end
	end

	assign scan_done = done_q;

	////////////////////////////////////////////////////////////////////////////
	// User read port of the collected words; word 0 reads zero.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			user_q <= WORD_RST;
		end else begin
			user_q <= (user_sel == 4'h0) ? WORD_RST : image_q[user_sel];
		end
	end

	assign user_data = user_q;
endmodule : hsx_host

// [verif/hsx_chk.sv]
`timescale 1ns/100ps
module hsx_chk (
	// Clock and reset.
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	// Signals of the scan link.
	input  wire logic                      scan_strobe,
	input  wire hsx_pkg::hsx_word_t        cmd_word,
	input  wire logic                      word_rd,
	input  wire logic [hsx_pkg::SEL_W-1:0] word_sel,
	input  wire hsx_pkg::hsx_word_t        word_data,
	input  wire logic                      word_ack,
	input  wire hsx_pkg::hsx_word_t        status_bits
);
	import hsx_pkg::*;
	logic       rst_lat0;                 // Strobe cycle carrying latch reset bit 0.
	logic       clr_err;                  // Strobe cycle carrying the clear-error bit.
	logic       prev_rst0_q;              // Latch reset bit 0 of the previous scan.
	logic [3:0] en_q, en_q1, en_q2;       // Enables taken at the strobe, and two delayed copies.
	assign rst_lat0 = scan_strobe & cmd_word[CB_RESET];
	assign clr_err  = scan_strobe & cmd_word[CB_CLR_ERR];
	////////////////////////////////////////////////////////////////////////////////
	// Remember the previous reset bit and the enables over the output pipeline.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_rst0_q <= 1'b0;
			en_q        <= 4'h0;
		end else if (scan_strobe) begin
			prev_rst0_q <= cmd_word[CB_RESET];
			en_q        <= cmd_word[12:9];
		end
	end
	// The delayed copies cover the cycles in which old gating is still in flight.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q1 <= 4'h0;
			en_q2 <= 4'h0;
		end else begin
			en_q1 <= en_q;
			en_q2 <= en_q1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_latch_hold: assert property (status_bits[0] && !rst_lat0 && !$past(rst_lat0) |=> status_bits[0])
		else $error("latch bit dropped without reset");
	a_latch_clear: assert property (rst_lat0 |-> ##2 !status_bits[0])
		else $error("latch bit not cleared by reset bit");
	a_reset_one_scan: assert property (scan_strobe && prev_rst0_q |-> !cmd_word[CB_RESET])
		else $error("reset bit held for a second scan");
	a_ready_sticky: assert property (status_bits[SB_READY] |=> status_bits[SB_READY])
		else $error("ready bit dropped");
	a_error_hold: assert property (status_bits[SB_ERROR] && !clr_err && !$past(clr_err)
		|=> $stable(status_bits[SB_ERROR]))
		else $error("error bit dropped without clear");
	a_error_clear: assert property (clr_err |-> ##2 !status_bits[SB_ERROR])
		else $error("error bit not cleared");
	a_out_gated: assert property ((status_bits[12:9] & ~(en_q | en_q1 | en_q2)) == 4'h0)
		else $error("output shown on while disabled");
	a_ack_follows: assert property (word_rd |=> word_ack)
		else $error("word read not answered");
	a_ack_cause: assert property (word_ack |-> $past(word_rd))
		else $error("answer without read");
	// Main scenarios.
	c_latch_reset: cover property (rst_lat0);
	c_error_clear: cover property (clr_err);
	c_last_word: cover property (word_ack && word_sel == 4'hF && word_data == 16'h000F);
endmodule : hsx_chk

// [verif/hsx_tb.sv]
`timescale 1ns/100ps
module hsx_tb;
	import hsx_pkg::*;
	// Clock, reset and device-side stimulus; counter values make word n read n.
	logic        sys_clk = 1'b0, rst_n = 1'b0, cfg_single = 1'b0;
	logic [5:0]  latch_evt = 6'h00;
	logic        home_found_evt = 1'b0, err_evt = 1'b0, selftest_done = 1'b0, selftest_fail = 1'b0;
	hsx_word_t   err_code = 16'h0000, rate1 = 16'h0002, rate2 = 16'h0003;
	logic [1:0]  disable_pin = 2'h0;
	logic        home_pin = 1'b0;
	logic [31:0] accum1 = 32'h0005_0004, accum2 = 32'h000B_000A;
	logic [31:0] capture [0:3] = '{32'h0007_0006, 32'h0009_0008, 32'h000D_000C, 32'h000F_000E};
	logic [3:0]  out_req = 4'hF, out_on, out_enable = 4'h0, user_sel = 4'h0;
	logic        home_cmd, scan_go = 1'b0, home_request = 1'b0, err_ack = 1'b0, scan_busy, scan_done;
	hsx_word_t   status_q, user_data;
	int          bad_count = 0, num_checks = 0;
	always #20 sys_clk = ~sys_clk;
	hsx_if u_hsx_if ();
	hsx_dev u_hsx_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(u_hsx_if), .cfg_single(cfg_single),
		.latch_evt(latch_evt), .home_found_evt(home_found_evt), .err_evt(err_evt), .err_code(err_code),
		.selftest_done(selftest_done), .selftest_fail(selftest_fail), .disable_pin(disable_pin),
		.home_pin(home_pin), .rate1(rate1), .rate2(rate2), .accum1(accum1), .accum2(accum2),
		.capture(capture), .out_req(out_req), .out_on(out_on), .home_cmd(home_cmd));
	hsx_host u_hsx_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(u_hsx_if), .scan_go(scan_go),
		.out_enable(out_enable), .home_request(home_request), .err_ack(err_ack), .scan_busy(scan_busy),
		.scan_done(scan_done), .status_q(status_q), .user_sel(user_sel), .user_data(user_data));
	hsx_chk u_hsx_chk (.sys_clk(sys_clk), .rst_n(rst_n), .scan_strobe(u_hsx_if.scan_strobe),
		.cmd_word(u_hsx_if.cmd_word), .word_rd(u_hsx_if.word_rd), .word_sel(u_hsx_if.word_sel),
		.word_data(u_hsx_if.word_data), .word_ack(u_hsx_if.word_ack), .status_bits(u_hsx_if.status_bits));
	////////////////////////////////////////////////////////////////////////////////
	// Compare one word and count it.
	task automatic check(input hsx_word_t got, input hsx_word_t exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Hold reset for 16 cycles, choosing the layout while it is held.
	task automatic do_reset(input logic single);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		cfg_single <= single;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask : do_reset
	// Run one scan and wait a bounded time for its done pulse.
	task automatic do_scan();
		int n;
		@(posedge sys_clk);
		scan_go <= 1'b1;
		@(posedge sys_clk);
		scan_go <= 1'b0;
		#1 check({15'h0000, scan_busy}, 16'h0001);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (scan_done !== 1'b1 && n < 60);
		check({15'h0000, scan_done}, 16'h0001);
		check({15'h0000, scan_busy}, 16'h0000);
	endtask : do_scan
	// Read one image word of the last scan through the user port.
	task automatic rd_word(input logic [3:0] sel, input hsx_word_t exp);
		@(posedge sys_clk);
		user_sel <= sel;
		repeat (2) @(posedge sys_clk);
		#1 check(user_data, exp);
	endtask : rd_word
	// Print the counts and the verdict, then stop.
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////////////
	// Cut a hang short; the tests need well under 5000 cycles.
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		give_verdict();
	end
	// Main sequence of tests.
	initial begin
		do_reset(1'b0);
		do_scan();
		check(status_q & 16'h4000, 16'h0000);
		@(posedge sys_clk);
		selftest_done <= 1'b1;
		do_scan();
		check(status_q & 16'h4000, 16'h4000);
		for (int n = 1; n < 16; n++) rd_word(n[3:0], (n == 1) ? 16'h0000 : 16'(n));
		$display("dual layout test done");
		@(posedge sys_clk);
		disable_pin <= 2'h2;
		repeat (4) @(posedge sys_clk);
		do_scan();
		check(status_q & 16'h00C0, 16'h0080);
		@(posedge sys_clk);
		latch_evt <= 6'h21;
		@(posedge sys_clk);
		latch_evt <= 6'h00;
		do_scan();
		check(status_q & 16'h003F, 16'h0021);
		do_scan();
		check(u_hsx_if.cmd_word & 16'h003F, 16'h0021);
		check(status_q & 16'h003F, 16'h0000);
		do_scan();
		check(u_hsx_if.cmd_word & 16'h003F, 16'h0000);
		$display("latch test done");
		@(posedge sys_clk);
		out_enable <= 4'h5;
		do_scan();
		check({12'h000, out_on}, 16'h0005);
		check(status_q & 16'h1E00, 16'h0A00);
		@(posedge sys_clk);
		out_req <= 4'h6;
		repeat (3) @(posedge sys_clk);
		#1 check({12'h000, out_on}, 16'h0004);
		$display("output test done");
		@(posedge sys_clk);
		err_evt <= 1'b1;
		err_code <= 16'h000A;
		@(posedge sys_clk);
		err_evt <= 1'b0;
		do_scan();
		check(status_q & 16'h8000, 16'h8000);
		rd_word(4'h1, 16'h000A);
		@(posedge sys_clk);
		err_ack <= 1'b1;
		@(posedge sys_clk);
		err_ack <= 1'b0;
		do_scan();
		do_scan();
		check(status_q & 16'h8000, 16'h0000);
		rd_word(4'h1, 16'h0000);
		$display("error test done");
		do_reset(1'b1);
		@(posedge sys_clk);
		disable_pin <= 2'h1;
		home_pin <= 1'b1;
		home_request <= 1'b1;
		do_scan();
		check({15'h0000, home_cmd}, 16'h0001);
		@(posedge sys_clk);
		home_found_evt <= 1'b1;
		@(posedge sys_clk);
		home_found_evt <= 1'b0;
		do_scan();
		check(status_q & 16'h00C0, 16'h00C0);
		check(status_q & 16'h0100, 16'h0100);
		// Single layout: the third capture (words 12 and 13 of the stimulus) reads at words 10 and 11.
		for (int n = 1; n < 16; n++) rd_word(n[3:0], (n == 1 || n == 3 || n > 11) ? 16'h0 : 16'(n > 9 ? n + 2 : n));
		$display("single layout test done");
		give_verdict();
	end
endmodule : hsx_tb
